// ===== hdl/wrc_consts.svh
`ifndef WRC_CONSTS_SVH
`define WRC_CONSTS_SVH

// Register byte offsets
`define WRC_OFS_CTRL      8'h00
`define WRC_OFS_STATUS    8'h04
`define WRC_OFS_MAIN_MAP  8'h08
`define WRC_OFS_WARN_MAP  8'h0C
`define WRC_OFS_IRQ_STAT  8'h10
`define WRC_OFS_IRQ_MASK  8'h14

// Control register fields
`define WRC_CTRL_MODE_LSB   0
`define WRC_CTRL_MODE_MSB   1
`define WRC_CTRL_RACK_BIT   2
`define WRC_CTRL_IACK_BIT   3
`define WRC_CTRL_TEST_BIT   4

// Assignment bitmap positions
`define WRC_MAP_WARN_BIT    0
`define WRC_MAP_INS_BIT     4
`define WRC_MAP_INH_BIT     8
`define WRC_MAP_SYS_BIT     16
`define WRC_MAP_PROD_BIT    24

// Writable masks and reset values of the bitmaps
`define WRC_MAIN_MAP_WMASK  32'h0101_0101
`define WRC_WARN_MAP_WMASK  32'h0101_0110
`define WRC_MAIN_MAP_RST    32'h0101_0010
`define WRC_WARN_MAP_RST    32'h0000_0011

// Interrupt status bits
`define WRC_IRQ_CHG_BIT     0
`define WRC_IRQ_TEST_BIT    1
`define WRC_IRQ_MEAS_BIT    2
`define WRC_IRQ_REJ_BIT     3
`define WRC_IRQ_WIDTH       4

// Timing
`define WRC_CLK_MHZ         200
`define WRC_TEST_TIME_MS    3000

`endif

// ===== hdl/wrc_pkg.sv
package wrc_pkg;

	// Warning relay operating modes
	typedef enum logic [1:0] {
		WRC_MODE_FAILSAFE = 2'b00,
		WRC_MODE_STANDARD = 2'b01,
		WRC_MODE_MIRROR   = 2'b10
	} wrc_mode_type;

	// Register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} wrc_bus_type;

	// Measurement and device status from the measuring core
	typedef struct packed {
		logic warn_fault;
		logic ins_fault;
		logic ins_acked;
		logic transient;
		logic inj_inhibited;
		logic inj_disconnected;
		logic over_voltage;
		logic over_capacitance;
		logic product_error;
		logic meas_done;
		logic device_ok;
		logic main_relay_on;
	} wrc_fault_type;

endpackage : wrc_pkg

// ===== hdl/wrc_warning_relay.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "wrc_consts.svh"
// Overview of operation
// - Mode selectable: failsafe, standard, mirror; failsafe default
// - Failsafe: energized with no fault or transient
// - Failsafe: energized with acked insulation fault only if acknowledge on
// - Failsafe: energized while inhibited, inhibit-acknowledge on
// - Failsafe: off in first measurement or fault
// - Relay self-test inverts resting state three seconds
// - Standard: energized on warning or insulation fault
// - Standard: off when quiet, acked, or inhibited with inhibit-acknowledge on
// - Mirror: copy main relay while device healthy
// - Mirror: stop copying when device inoperative
// - Assignments changed only through the communication port
// - Relay sources: warning, insulation, inhibit, system error, product error
// - System error: disconnection, over-voltage, over-capacitance
// - Bitmap bits: 0, 4, 8, 16, 24
// - Mirror mode clears and locks warning bitmap
module wrc_warning_relay #(
	parameter int unsigned TEST_CYCLES = `WRC_TEST_TIME_MS * 1000 * `WRC_CLK_MHZ
) (
	input  wire logic               ref_clk,
	input  wire logic               sys_rst,
	input  wire wrc_pkg::wrc_bus_type   bus,
	input  wire wrc_pkg::wrc_fault_type flt,
	output logic [31:0]             rd_data,
	output logic                    warn_relay,
	output logic                    irq
);

	wrc_pkg::wrc_mode_type mode_q;
	logic                  relay_ack_q;
	logic                  inhibit_ack_q;
	logic [31:0]           main_map_q;
	logic [31:0]           warn_map_q;
	logic                  first_meas_q;
	logic                  test_act_q;
	logic [31:0]           test_cnt_q;
	logic                  warn_relay_q;
	logic                  warn_relay_d;
	logic [31:0]           rd_data_q;
	logic [`WRC_IRQ_WIDTH-1:0] irq_stat_q;
	logic [`WRC_IRQ_WIDTH-1:0] irq_mask_q;
	logic [`WRC_IRQ_WIDTH-1:0] irq_evt;
	logic                  irq_q;
	logic [31:0]           src_vec;
	logic                  sys_err;
	logic                  ins_alarm;
	logic                  alarm;
	logic                  rest_on;
	logic                  wr_ctrl;
	logic                  test_start;
	logic                  test_end;
	logic                  map_reject;

	// Byte offset match for a write strobe
	function automatic logic wr_hit(input wrc_pkg::wrc_bus_type b, input logic [7:0] ofs);
		return b.wr && (b.addr == ofs);
	endfunction : wr_hit

	assign wr_ctrl = wr_hit(bus, `WRC_OFS_CTRL);

	// Condition set treated as system error
	assign sys_err = flt.inj_disconnected | flt.over_voltage | flt.over_capacitance;

	// Insulation fault counts unless acknowledged with acknowledge enabled
	assign ins_alarm = flt.ins_fault & ~(flt.ins_acked & relay_ack_q);

	// Assignable sources placed on their bitmap positions
	always_comb begin
		src_vec = 32'h0000_0000;
		src_vec[`WRC_MAP_WARN_BIT] = flt.warn_fault;
		src_vec[`WRC_MAP_INS_BIT]  = ins_alarm;
		src_vec[`WRC_MAP_INH_BIT]  = flt.inj_inhibited;
		src_vec[`WRC_MAP_SYS_BIT]  = sys_err;
		src_vec[`WRC_MAP_PROD_BIT] = flt.product_error;
	end

	// Alarm from assigned sources; acked inhibition forces resting state
	assign alarm = (|(src_vec & warn_map_q)) & ~(flt.inj_inhibited & inhibit_ack_q);

	// Resting state before self-test inversion
	always_comb begin
		rest_on = 1'b0;
		unique case (mode_q)
			wrc_pkg::WRC_MODE_FAILSAFE: rest_on = ~first_meas_q & ~alarm;
			wrc_pkg::WRC_MODE_STANDARD: rest_on = ~first_meas_q & alarm;
			wrc_pkg::WRC_MODE_MIRROR:   rest_on = 1'b0;
			default:                    rest_on = 1'b0;
		endcase
	end

	// Final relay drive: mirror copies only while healthy, test inverts
	always_comb begin
		if (mode_q == wrc_pkg::WRC_MODE_MIRROR) begin
			warn_relay_d = flt.device_ok & flt.main_relay_on;
		end else begin
			warn_relay_d = rest_on ^ test_act_q;
		end
	end

	// Relay output register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			warn_relay_q <= 1'b0;
		end else begin
			warn_relay_q <= warn_relay_d;
		end
	end

	// First measurement phase from reset to first result
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			first_meas_q <= 1'b1;
		end else if (flt.meas_done) begin
			first_meas_q <= 1'b0;
		end
	end

	// Mode and acknowledge settings
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mode_q        <= wrc_pkg::WRC_MODE_FAILSAFE;
			relay_ack_q   <= 1'b0;
			inhibit_ack_q <= 1'b0;
		end else if (wr_ctrl) begin
			if (bus.wdata[`WRC_CTRL_MODE_MSB:`WRC_CTRL_MODE_LSB] != 2'b11) begin
				mode_q <= wrc_pkg::wrc_mode_type'(
					bus.wdata[`WRC_CTRL_MODE_MSB:`WRC_CTRL_MODE_LSB]);
			end
			relay_ack_q   <= bus.wdata[`WRC_CTRL_RACK_BIT];
			inhibit_ack_q <= bus.wdata[`WRC_CTRL_IACK_BIT];
		end
	end

	// Self-test start only outside mirror mode and when idle
	assign test_start = wr_ctrl && bus.wdata[`WRC_CTRL_TEST_BIT] && !test_act_q
		&& (mode_q != wrc_pkg::WRC_MODE_MIRROR);
	assign test_end = test_act_q && (test_cnt_q == TEST_CYCLES - 1);

	// Self-test timer, inversion lasts TEST_CYCLES cycles
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			test_act_q <= 1'b0;
			test_cnt_q <= 32'h0000_0000;
		end else if (test_start) begin
			test_act_q <= 1'b1;
			test_cnt_q <= 32'h0000_0000;
		end else if (test_end) begin
			test_act_q <= 1'b0;
			test_cnt_q <= 32'h0000_0000;
		end else if (test_act_q) begin
			test_cnt_q <= test_cnt_q + 32'h0000_0001;
		end
	end

	// Bitmap write attempt on the warning map while mirroring
	assign map_reject = wr_hit(bus, `WRC_OFS_WARN_MAP) && (mode_q == wrc_pkg::WRC_MODE_MIRROR);

	// Main assignment bitmap, written only over the register port
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			main_map_q <= `WRC_MAIN_MAP_RST;
		end else if (wr_hit(bus, `WRC_OFS_MAIN_MAP)) begin
			main_map_q <= (main_map_q & ~`WRC_MAIN_MAP_WMASK)
				| (bus.wdata & `WRC_MAIN_MAP_WMASK);
		end
	end

	// Warning bitmap, cleared and locked while mirroring
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			warn_map_q <= `WRC_WARN_MAP_RST;
		end else if (mode_q == wrc_pkg::WRC_MODE_MIRROR) begin
			warn_map_q <= 32'h0000_0000;
		end else if (wr_hit(bus, `WRC_OFS_WARN_MAP)) begin
			warn_map_q <= (warn_map_q & ~`WRC_WARN_MAP_WMASK)
				| (bus.wdata & `WRC_WARN_MAP_WMASK);
		end
	end

	// Interrupt events
	always_comb begin
		irq_evt = '0;
		irq_evt[`WRC_IRQ_CHG_BIT]  = warn_relay_d ^ warn_relay_q;
		irq_evt[`WRC_IRQ_TEST_BIT] = test_end;
		irq_evt[`WRC_IRQ_MEAS_BIT] = first_meas_q & flt.meas_done;
		irq_evt[`WRC_IRQ_REJ_BIT]  = map_reject;
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_stat_q <= '0;
		end else if (wr_hit(bus, `WRC_OFS_IRQ_STAT)) begin
			irq_stat_q <= (irq_stat_q & ~bus.wdata[`WRC_IRQ_WIDTH-1:0]) | irq_evt;
		end else begin
			irq_stat_q <= irq_stat_q | irq_evt;
		end
	end

	// Interrupt mask
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_mask_q <= '0;
		end else if (wr_hit(bus, `WRC_OFS_IRQ_MASK)) begin
			irq_mask_q <= bus.wdata[`WRC_IRQ_WIDTH-1:0];
		end
	end

	// Level interrupt, registered
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Read data, valid the cycle after the read strobe only
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_data_q <= 32'h0000_0000;
		end else if (bus.rd) begin
			unique case (bus.addr)
				`WRC_OFS_CTRL: rd_data_q <= {28'h000_0000, inhibit_ack_q, relay_ack_q,
					mode_q};
				`WRC_OFS_STATUS: rd_data_q <= {27'h000_0000, flt.main_relay_on,
					alarm, test_act_q, first_meas_q, warn_relay_q};
				`WRC_OFS_MAIN_MAP: rd_data_q <= main_map_q;
				`WRC_OFS_WARN_MAP: rd_data_q <= warn_map_q;
				`WRC_OFS_IRQ_STAT: rd_data_q <= {28'h000_0000, irq_stat_q};
				`WRC_OFS_IRQ_MASK: rd_data_q <= {28'h000_0000, irq_mask_q};
				default:           rd_data_q <= 32'h0000_0000;
			endcase
		end else begin
			rd_data_q <= 32'h0000_0000;
		end
	end

	assign rd_data    = rd_data_q;
	assign warn_relay = warn_relay_q;
	assign irq        = irq_q;

	// Checks on the relay behaviour
	a_mode_reset_fs: assert property (@(posedge ref_clk)
		$fell(sys_rst) |-> mode_q == wrc_pkg::WRC_MODE_FAILSAFE)
		else $error("mode not failsafe after reset");

	a_fs_quiet_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == wrc_pkg::WRC_MODE_FAILSAFE && !first_meas_q && !test_act_q
		&& !flt.warn_fault && !flt.ins_fault && !flt.inj_inhibited && !sys_err
		&& !flt.product_error) |=> warn_relay_q)
		else $error("failsafe relay off with no fault");

	a_ack_fault_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == wrc_pkg::WRC_MODE_FAILSAFE && !first_meas_q && !test_act_q
		&& flt.ins_fault && flt.ins_acked && relay_ack_q && !flt.warn_fault
		&& !(|(src_vec & warn_map_q & ~(32'h1 << `WRC_MAP_INS_BIT))))
		|=> warn_relay_q)
		else $error("acked fault did not leave relay energized");

	a_fs_inhibit_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == wrc_pkg::WRC_MODE_FAILSAFE && !first_meas_q && !test_act_q
		&& flt.inj_inhibited && inhibit_ack_q) |=> warn_relay_q)
		else $error("inhibited relay not energized");

	a_first_meas_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q != wrc_pkg::WRC_MODE_MIRROR && first_meas_q && !test_act_q)
		|=> !warn_relay_q)
		else $error("relay energized during first measurement");

	a_test_window: assert property (@(posedge ref_clk) disable iff (sys_rst)
		test_act_q |-> (test_cnt_q < TEST_CYCLES))
		else $error("self-test ran past its window");

	a_test_invert: assert property (@(posedge ref_clk) disable iff (sys_rst)
		test_start |=> test_act_q ##1 (warn_relay_q == !rest_on || $changed(rest_on)))
		else $error("self-test did not invert relay");

	a_std_fault_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == wrc_pkg::WRC_MODE_STANDARD && !first_meas_q && !test_act_q
		&& flt.warn_fault && warn_map_q[`WRC_MAP_WARN_BIT]
		&& !(flt.inj_inhibited && inhibit_ack_q)) |=> warn_relay_q)
		else $error("standard relay off on warning fault");

	a_std_quiet_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == wrc_pkg::WRC_MODE_STANDARD && !test_act_q && !alarm)
		|=> !warn_relay_q)
		else $error("standard relay on with no alarm");

	a_mirror_copy: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == wrc_pkg::WRC_MODE_MIRROR)
		|=> warn_relay_q == ($past(flt.device_ok) & $past(flt.main_relay_on)))
		else $error("mirror relay does not follow main relay");

	a_mirror_map_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == wrc_pkg::WRC_MODE_MIRROR) ##1 (mode_q == wrc_pkg::WRC_MODE_MIRROR)
		|-> warn_map_q == 32'h0000_0000)
		else $error("warning bitmap not cleared in mirror mode");

	a_meas_phase_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
		flt.meas_done |=> !first_meas_q ##1 !first_meas_q)
		else $error("first measurement phase did not end");

	a_fs_ack_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == wrc_pkg::WRC_MODE_FAILSAFE && !first_meas_q && !test_act_q
		&& flt.ins_fault && !relay_ack_q && warn_map_q[`WRC_MAP_INS_BIT]
		&& !(flt.inj_inhibited && inhibit_ack_q)) |=> !warn_relay_q)
		else $error("insulation fault left failsafe relay on");

	a_fs_sys_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == wrc_pkg::WRC_MODE_FAILSAFE && !first_meas_q && !test_act_q
		&& sys_err && warn_map_q[`WRC_MAP_SYS_BIT]
		&& !(flt.inj_inhibited && inhibit_ack_q)) |=> !warn_relay_q)
		else $error("system error left failsafe relay on");

	a_std_inh_src: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == wrc_pkg::WRC_MODE_STANDARD && !first_meas_q && !test_act_q
		&& flt.inj_inhibited && warn_map_q[`WRC_MAP_INH_BIT] && !inhibit_ack_q)
		|=> warn_relay_q)
		else $error("assigned inhibit source did not energize relay");

	a_warn_map_rsv: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(warn_map_q & ~(`WRC_WARN_MAP_WMASK | 32'h0000_0001)) == 32'h0000_0000)
		else $error("reserved warning bitmap bit set");

	a_main_map_rsv: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(main_map_q & ~(`WRC_MAIN_MAP_WMASK | 32'h0000_0010)) == 32'h0000_0000)
		else $error("reserved main bitmap bit set");

	a_main_map_port: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(bus.wr && bus.addr == `WRC_OFS_MAIN_MAP) |=> $stable(main_map_q))
		else $error("main bitmap changed without a port write");

	a_map_reject_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(bus.wr && bus.addr == `WRC_OFS_WARN_MAP && mode_q == wrc_pkg::WRC_MODE_MIRROR)
		|=> irq_stat_q[`WRC_IRQ_REJ_BIT])
		else $error("rejected bitmap write not flagged");

	a_mode_code_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(bus.wr && bus.addr == `WRC_OFS_CTRL
		&& bus.wdata[`WRC_CTRL_MODE_MSB:`WRC_CTRL_MODE_LSB] == 2'b11) |=> $stable(mode_q))
		else $error("illegal mode code changed the mode");

endmodule : wrc_warning_relay

// ===== verif/warning_relay_output_control_test.sv
`timescale 1ns/1ps
`include "wrc_consts.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
	$display("FAIL t=%0t got %0h exp %0h", $time, a, e); end end
module warning_relay_output_control_test;
	typedef struct {
		logic [31:0] val;
		logic [31:0] msk;
	} wrc_note_type;

	localparam int          TCYC = 20;
	logic                   ref_clk = 1'b0;
	logic                   sys_rst = 1'b1;
	wrc_pkg::wrc_bus_type   bus = '0;
	wrc_pkg::wrc_fault_type flt = '0;
	logic [31:0]            rd_data;
	logic                   warn_relay;
	logic                   irq;
	logic                   alarm_seen;
	logic                   failure_seen;
	logic                   rd_d1_q = 1'b0;
	logic [31:0]            seed = 32'h75D16392;
	int                     n_mismatch = 0;
	int                     checks_done = 0;
	wrc_note_type           notes[$];

	// Clock at 200 MHz
	always #2.5 ref_clk = ~ref_clk;

	wrc_warning_relay #(.TEST_CYCLES(TCYC)) uut (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.bus        (bus),
		.flt        (flt),
		.rd_data    (rd_data),
		.warn_relay (warn_relay),
		.irq        (irq)
	);

	wrc_plc_model plc (
		.contact_1    (warn_relay),
		.contact_2    (flt.main_relay_on),
		.alarm_seen   (alarm_seen),
		.failure_seen (failure_seen)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Expected alarm and relay level outside mirror mode
	function automatic logic [1:0] exp_fs(input logic std, input logic rack, input logic iack,
		input logic [31:0] map, input wrc_pkg::wrc_fault_type f);
		logic [31:0] src;
		logic        al;
		src = '0;
		src[0]  = f.warn_fault;
		src[4]  = f.ins_fault & ~(f.ins_acked & rack);
		src[8]  = f.inj_inhibited;
		src[16] = f.inj_disconnected | f.over_voltage | f.over_capacitance;
		src[24] = f.product_error;
		al = (|(src & map)) & ~(f.inj_inhibited & iack);
		return {al, std ? al : ~al};
	endfunction : exp_fs

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{e, m});
		@(posedge ref_clk);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
	endtask : rd

	// Each read result takes the oldest note
	always @(posedge ref_clk) begin
		rd_d1_q <= bus.rd & ~sys_rst;
		if (rd_d1_q && notes.size() > 0) begin
			`CHK(rd_data & notes[0].msk, notes[0].val)
			void'(notes.pop_front());
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	// Main sequence
	initial begin
		logic [31:0]            map;
		logic [1:0]             e;
		wrc_pkg::wrc_fault_type f;
		int                     cnt;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(`WRC_OFS_CTRL, 32'h0, 32'hF);
		rd(`WRC_OFS_STATUS, 32'h2, 32'h3);
		rd(`WRC_OFS_WARN_MAP, 32'h0000_0011, 32'hFFFF_FFFF);
		rd(`WRC_OFS_MAIN_MAP, 32'h0101_0010, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0, 32'hFFFF_FFFF);
		$display("test reset done");
		// First measurement ends, interrupt masked then unmasked
		@(posedge ref_clk) flt.meas_done <= 1'b1;
		@(posedge ref_clk) flt.meas_done <= 1'b0;
		tick(2);
		`CHK(warn_relay, 1'b1)
		`CHK(irq, 1'b0)
		rd(`WRC_OFS_IRQ_STAT, 32'h5, 32'hF);
		wr(`WRC_OFS_IRQ_MASK, 32'h4);
		tick(2);
		`CHK(irq, 1'b1)
		wr(`WRC_OFS_IRQ_STAT, 32'h4);
		tick(2);
		`CHK(irq, 1'b0)
		$display("test first measurement done");
		// Random faults and settings in failsafe and standard modes
		wr(`WRC_OFS_WARN_MAP, 32'h0101_0110);
		map = 32'h0101_0111;
		rd(`WRC_OFS_WARN_MAP, map, 32'hFFFF_FFFF);
		for (int i = 0; i < 48; i++) begin
			seed = lfsr(seed);
			wr(`WRC_OFS_CTRL, {28'h0, seed[13], seed[12], 1'b0, seed[14]});
			f = wrc_pkg::wrc_fault_type'({seed[11:3], 1'b0, seed[2:1]});
			@(posedge ref_clk) flt <= f;
			e = exp_fs(seed[14], seed[12], seed[13], map, f);
			tick(2);
			`CHK(warn_relay, e[0])
			rd(`WRC_OFS_STATUS, {28'h0, e[1], 2'b0, e[0]}, 32'h9);
		end
		$display("test random faults done");
		// Acknowledged insulation fault, relay acknowledge on then off
		@(posedge ref_clk) flt <= '0;
		for (int a = 0; a < 2; a++) begin
			wr(`WRC_OFS_CTRL, {29'h0, 1'(a == 0), 2'h0});
			@(posedge ref_clk) flt <= '{ins_fault: 1'b1, ins_acked: 1'b1, default: 1'b0};
			tick(2);
			`CHK(warn_relay, 1'(a == 0))
		end
		$display("test acknowledge done");
		// Self-test inverts the resting level in both modes
		@(posedge ref_clk) flt <= '0;
		for (int m = 0; m < 2; m++) begin
			wr(`WRC_OFS_CTRL, m);
			tick(2);
			`CHK(warn_relay, 1'(m == 0))
			wr(`WRC_OFS_CTRL, 32'h10 | m);
			cnt = 0;
			for (int k = 0; k < 200; k++) begin
				tick(1);
				if (warn_relay !== 1'(m == 0)) cnt++;
				else if (cnt > 0) break;
			end
			`CHK(cnt, TCYC)
			rd(`WRC_OFS_IRQ_STAT, 32'h2, 32'h2);
			wr(`WRC_OFS_IRQ_STAT, 32'hF);
		end
		$display("test self-test done");
		// Mirror mode copies the main relay while healthy
		wr(`WRC_OFS_CTRL, 32'h2);
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk);
			flt.device_ok     <= (k != 3);
			flt.main_relay_on <= (k != 1);
			tick(2);
			`CHK(warn_relay, (k % 2 == 0))
			`CHK(failure_seen, (k % 2 == 1))
			`CHK(alarm_seen, (k % 2 == 0))
		end
		rd(`WRC_OFS_WARN_MAP, 32'h0, 32'hFFFF_FFFF);
		wr(`WRC_OFS_WARN_MAP, 32'h0000_0100);
		rd(`WRC_OFS_WARN_MAP, 32'h0, 32'hFFFF_FFFF);
		rd(`WRC_OFS_IRQ_STAT, 32'h8, 32'h8);
		wr(`WRC_OFS_CTRL, 32'h3);
		rd(`WRC_OFS_CTRL, 32'h2, 32'h3);
		tick(3);
		`CHK(notes.size(), 0)
		$display("test mirror done");
		finish_test();
	end
endmodule : warning_relay_output_control_test

// ===== verif/wrc_plc_model.sv
`timescale 1ns/1ps
module wrc_plc_model (
	input  wire logic contact_1,
	input  wire logic contact_2,
	output logic      alarm_seen,
	output logic      failure_seen
);
	// Controller decoding of the two series-wired relay inputs
	assign alarm_seen   = contact_1 & contact_2;
	assign failure_seen = ~contact_1;
endmodule : wrc_plc_model
